// ==== rtl/rsmd_pkg.sv ====
// Package for the RS-485 multidrop control block
package rsmd_pkg;
  // Register offsets
  localparam logic [3:0] OFS_EXTRA_FEATURE  = 4'h0;
  localparam logic [3:0] OFS_ENH_FEATURE    = 4'h1;
  localparam logic [3:0] OFS_LINE_FORMAT    = 4'h2;
  localparam logic [3:0] OFS_INT_ENABLE     = 4'h3;
  localparam logic [3:0] OFS_PAUSE_CHAR2    = 4'h4;
  localparam logic [3:0] OFS_EVT_STATUS     = 4'h5;
  localparam logic [3:0] OFS_EVT_MASK       = 4'h6;
  localparam logic [3:0] OFS_LINK_STATUS    = 4'h7;
  // Field positions
  localparam int EXF_MULTIDROP   = 0;
  localparam int EXF_RX_OFF      = 1;
  localparam int EXF_DIR_BY_TX   = 4;
  localparam int EXF_DIR_INVERT  = 5;
  localparam int ENH_SPECIAL     = 5;
  localparam int IEN_LINE_STATUS = 2;
  localparam int LSF_PARITY_ERR  = 2;
  localparam logic [2:0] LFC_FORCE_PAR0 = 3'h7;
  // Reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RST_EVENTS  = 2'h0;
  // Event bit positions
  localparam int EV_ADDR_STORED  = 0;
  localparam int EV_ADDR_DROPPED = 1;

  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
  } rsmd_char_t;

  typedef struct packed {
    logic       push;
    logic       parity_err;
    logic [7:0] data;
  } rsmd_fifo_wr_t;
endpackage

// ==== rtl/rsmd_ctrl.sv ====
// RS-485 direction control and multidrop receive gating
// Functional notes
// - Direction bit set: drive line low on FIFO write, high after last bit.
// - Invert bit with automatic direction control reverses direction polarity.
// - Inverted: high while data pending, low after final bit leaves shifter.
// - Extra feature control bit 0 selects 9-bit multidrop reception.
// - Ninth bit one marks an address character; zero marks data.
// - Normal mode with receiver disabled drops data, even after an address arrives.
// - Address character flags parity error, is stored, line status interrupt if enabled.
// - Enabled receiver accepts characters; new address again gives parity error.
// - Special matching with multidrop compares addresses against second pause char.
// - Automatic detection drops data and mismatched addresses, storing nothing.
// - Matching address enables receiver and is stored with ninth bit as parity.
// - Matching address raises line status interrupt if enable bit 2 set.
// - Later mismatched address disables receiver and is discarded.
// - Later matching address is stored, ninth bit in line status bit 2.
// - Receiver-off stops reception at once; outside multidrop the assembled character still moves to FIFO.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsmd_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rdata,
  input  wire logic                   host_dir_level,
  input  wire logic                   tx_fifo_write,
  input  wire logic                   tx_last_bit_done,
  input  wire rsmd_pkg::rsmd_char_t   rx_char,
  input  wire logic                   rx_shift_busy,
  output logic                        dir_out,
  output rsmd_pkg::rsmd_fifo_wr_t     rx_fifo_wr,
  output logic                        line_status_irq,
  output logic                        irq
);

  logic [7:0] extra_reg;
  logic [7:0] enh_reg;
  logic [7:0] lfc_reg;
  logic [7:0] ien_reg;
  logic [7:0] pause2_reg;
  logic [1:0] evt_reg;
  logic [1:0] evt_next;
  logic [1:0] mask_reg;
  logic       tx_pending_reg;
  logic       dir_reg;
  logic [7:0] rd_reg;
  logic       lsi_reg;
  logic       irq_reg;
  logic       last_perr_reg;
  rsmd_pkg::rsmd_fifo_wr_t fifo_reg;
  rsmd_pkg::rsmd_fifo_wr_t fifo_next;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = wr_stb && (a == ofs);
  endfunction

  wire multidrop  = extra_reg[rsmd_pkg::EXF_MULTIDROP];
  wire rx_enabled = ~extra_reg[rsmd_pkg::EXF_RX_OFF];
  wire auto_det   = multidrop && enh_reg[rsmd_pkg::ENH_SPECIAL];
  wire dir_by_tx  = extra_reg[rsmd_pkg::EXF_DIR_BY_TX];
  wire dir_inv    = extra_reg[rsmd_pkg::EXF_DIR_INVERT];
  wire ls_ien     = ien_reg[rsmd_pkg::IEN_LINE_STATUS];
  wire is_addr    = rx_char.valid && rx_char.ninth;
  wire is_data    = rx_char.valid && !rx_char.ninth;
  wire addr_match = (rx_char.data == pause2_reg);
  // Automatic match and mismatch outcomes
  wire auto_hit   = auto_det && is_addr && addr_match;
  wire auto_miss  = auto_det && is_addr && !addr_match;
  wire norm_store = !auto_det && rx_char.valid && (rx_enabled || (multidrop && is_addr));
  wire auto_store = auto_det && ((is_data && rx_enabled) || auto_hit);
  // in-flight char flush
  // Outside multidrop only, so a flushed byte never slips past address gating
  wire store      = norm_store || auto_store || (rx_char.valid && rx_shift_busy && !multidrop);
  wire addr_store = multidrop && is_addr && store;
  // Receiver-off next value; host write first, automatic update wins
  wire host_rx_wr = hit(addr, rsmd_pkg::OFS_EXTRA_FEATURE);
  wire rx_off_host = host_rx_wr ? wdata[rsmd_pkg::EXF_RX_OFF] : extra_reg[rsmd_pkg::EXF_RX_OFF];
  wire rx_off_next = auto_hit ? 1'b0 : (auto_miss ? 1'b1 : rx_off_host);
  wire dir_level  = dir_by_tx ? (tx_pending_reg ^ ~dir_inv) : host_dir_level;
  wire [1:0] evt_set = {auto_miss, addr_store};

  always_comb begin
    fifo_next.push       = store;
    fifo_next.data       = rx_char.data;
    fifo_next.parity_err = multidrop ? rx_char.ninth : 1'b0;
    evt_next = (evt_reg & ~(hit(addr, rsmd_pkg::OFS_EVT_STATUS) ? wdata[1:0] : 2'h0)) | evt_set;
  end

  always_comb begin
    unique case (addr)
      rsmd_pkg::OFS_EXTRA_FEATURE: rd_reg = extra_reg;
      rsmd_pkg::OFS_ENH_FEATURE:   rd_reg = enh_reg;
      rsmd_pkg::OFS_LINE_FORMAT:   rd_reg = lfc_reg;
      rsmd_pkg::OFS_INT_ENABLE:    rd_reg = ien_reg;
      rsmd_pkg::OFS_PAUSE_CHAR2:   rd_reg = pause2_reg;
      rsmd_pkg::OFS_EVT_STATUS:    rd_reg = {6'h00, evt_reg};
      rsmd_pkg::OFS_EVT_MASK:      rd_reg = {6'h00, mask_reg};
      rsmd_pkg::OFS_LINK_STATUS:   rd_reg = {5'h00, last_perr_reg, 1'b0, rx_enabled};
      default:                     rd_reg = rsmd_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extra_reg  <= rsmd_pkg::RST_BYTE;
      enh_reg    <= rsmd_pkg::RST_BYTE;
      lfc_reg    <= rsmd_pkg::RST_BYTE;
      ien_reg    <= rsmd_pkg::RST_BYTE;
      pause2_reg <= rsmd_pkg::RST_BYTE;
      mask_reg   <= rsmd_pkg::RST_EVENTS;
    end else begin
      if (host_rx_wr) begin
        extra_reg <= wdata;
      end
      extra_reg[rsmd_pkg::EXF_RX_OFF] <= rx_off_next;
      if (hit(addr, rsmd_pkg::OFS_ENH_FEATURE)) enh_reg <= wdata;
      if (hit(addr, rsmd_pkg::OFS_LINE_FORMAT)) lfc_reg <= wdata;
      if (hit(addr, rsmd_pkg::OFS_INT_ENABLE)) ien_reg <= wdata;
      if (hit(addr, rsmd_pkg::OFS_PAUSE_CHAR2)) pause2_reg <= wdata;
      if (hit(addr, rsmd_pkg::OFS_EVT_MASK)) mask_reg <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_pending_reg <= 1'b0;
    end else if (tx_fifo_write) begin
      tx_pending_reg <= 1'b1;
    end else if (tx_last_bit_done) begin
      tx_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_reg <= 1'b1;
    end else begin
      dir_reg <= dir_level;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_reg      <= '0;
      last_perr_reg <= 1'b0;
    end else begin
      fifo_reg <= fifo_next;
      if (store) last_perr_reg <= fifo_next.parity_err;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lsi_reg <= 1'b0;
      evt_reg <= rsmd_pkg::RST_EVENTS;
      irq_reg <= 1'b0;
    end else begin
      lsi_reg <= addr_store && ls_ien;
      // Set wins over clear
      evt_reg <= evt_next;
      irq_reg <= |(evt_next & mask_reg);
    end
  end

  // Read data valid only one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata   <= rsmd_pkg::RST_BYTE;
    end else begin
      rdata   <= rd_stb ? rd_reg : rsmd_pkg::RST_BYTE;
    end
  end

  assign dir_out         = dir_reg;
  assign rx_fifo_wr      = fifo_reg;
  assign line_status_irq = lsi_reg;
  assign irq             = irq_reg;

endmodule
`default_nettype wire

// ==== verification/rsmd_ctrl_properties.sv ====
// Port checker for the multidrop control block
`timescale 1ns/1ps
`default_nettype none
module rsmd_ctrl_chk (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [3:0]              addr,
  input wire logic [7:0]              wdata,
  input wire logic                    wr_stb,
  input wire logic                    rd_stb,
  input wire logic [7:0]              rdata,
  input wire logic                    tx_fifo_write,
  input wire rsmd_pkg::rsmd_char_t    rx_char,
  input wire logic                    dir_out,
  input wire rsmd_pkg::rsmd_fifo_wr_t rx_fifo_wr,
  input wire logic                    line_status_irq
);
  logic [7:0] exf_q, pch_q;
  logic       enh_q, ien_q;
  // Shadows of host writes; auto gating of bit 1 is not mirrored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {exf_q, pch_q, enh_q, ien_q} <= '0;
    end else if (wr_stb) begin
      if (addr == rsmd_pkg::OFS_EXTRA_FEATURE) exf_q <= wdata;
      if (addr == rsmd_pkg::OFS_PAUSE_CHAR2) pch_q <= wdata;
      if (addr == rsmd_pkg::OFS_ENH_FEATURE) enh_q <= wdata[5];
      if (addr == rsmd_pkg::OFS_INT_ENABLE) ien_q <= wdata[2];
    end
  end
  wire nrm = exf_q[0] & ~enh_q;
  wire aut = exf_q[0] & enh_q;
  wire va  = rx_char.valid & rx_char.ninth;
  wire vd  = rx_char.valid & ~rx_char.ninth;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_store_addr;
    ##1 (rx_fifo_wr.push && rx_fifo_wr.parity_err && rx_fifo_wr.data == $past(rx_char.data));
  endsequence
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_dir_assert: assert property (tx_fifo_write && exf_q[4] && !exf_q[5] |-> ##2 !dir_out)
    else $error("direction not driven low");
  a_dir_invert: assert property (tx_fifo_write && exf_q[4] && exf_q[5] |-> ##2 dir_out)
    else $error("inverted direction not high");
  a_data_drop: assert property (nrm && exf_q[1] && vd |=> !rx_fifo_wr.push)
    else $error("data kept while receiver off");
  a_addr_flag: assert property (nrm && va |-> s_store_addr)
    else $error("address not stored with error");
  a_auto_drop: assert property (aut && va && rx_char.data != pch_q |=> !rx_fifo_wr.push)
    else $error("mismatched address stored");
  a_match_store: assert property (aut && va && rx_char.data == pch_q |-> s_store_addr)
    else $error("matching address not stored");
  a_ls_irq: assert property (line_status_irq |->
    rx_fifo_wr.push && rx_fifo_wr.parity_err && $past(ien_q))
    else $error("line status pulse without cause");
endmodule
bind rsmd_ctrl rsmd_ctrl_chk chk_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_fifo_write(tx_fifo_write),
  .rx_char(rx_char), .dir_out(dir_out), .rx_fifo_wr(rx_fifo_wr),
  .line_status_irq(line_status_irq));
`default_nettype wire

// ==== verification/rsmd_station.sv ====
// Remote RS-485 station sending framed characters
`timescale 1ns/1ps
`default_nettype none
module rsmd_station (
  input  wire logic           clk,
  output rsmd_pkg::rsmd_char_t rx_char
);
  initial rx_char = '0;
  task automatic send(input logic n, input logic [7:0] d);
    rx_char <= {1'b1, n, d};
    @(posedge clk);
    // Idle shows inverted leftovers, never the old char
    rx_char <= {1'b0, ~n, ~d};
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the multidrop control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                    clk, rst_n, wr_stb, rd_stb, hdl, txw, txd, sb, dir_out, lsi, irq;
  logic [3:0]              addr;
  logic [7:0]              wdata, rdata;
  rsmd_pkg::rsmd_char_t    rx_char;
  rsmd_pkg::rsmd_fifo_wr_t rx_fifo_wr;
  int                      bad_count, tests_run, cyc;
  always #4 clk = ~clk;
  rsmd_station rsmd_station_i (.clk(clk), .rx_char(rx_char));
  rsmd_ctrl rsmd_ctrl_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .host_dir_level(hdl),
    .tx_fifo_write(txw), .tx_last_bit_done(txd), .rx_char(rx_char), .rx_shift_busy(sb),
    .dir_out(dir_out), .rx_fifo_wr(rx_fifo_wr), .line_status_irq(lsi), .irq(irq));
  task chk(string n, logic [10:0] s, logic [10:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge clk) wr_stb <= 1'b0;
    @(posedge clk);
  endtask
  task rd(logic [3:0] a, logic [7:0] e, string n);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk) rd_stb <= 1'b0;
    #1 chk(n, rdata, e);
    @(posedge clk);
  endtask
  task rx(logic n, logic [7:0] d, logic [10:0] e, string nm);
    rsmd_station_i.send(n, d);
    #1 chk(nm, {rx_fifo_wr, lsi}, e);
    @(posedge clk);
  endtask
  task txp(logic w, logic e, string n);
    if (w) txw <= 1'b1; else txd <= 1'b1;
    @(posedge clk) {txw, txd} <= 2'b00;
    repeat (2) @(posedge clk);
    #1 chk(n, dir_out, e);
    @(posedge clk);
  endtask
  task t_dir;
    hdl <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("host dir", dir_out, 1'b1);
    @(posedge clk);
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h10);
    txp(1'b1, 1'b0, "dir low");
    txp(1'b0, 1'b1, "dir idle");
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h30);
    txp(1'b1, 1'b1, "inv high");
    txp(1'b0, 1'b0, "inv idle");
  endtask
  task t_norm;
    wr(rsmd_pkg::OFS_ENH_FEATURE, 8'h00);
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h03);
    wr(rsmd_pkg::OFS_LINE_FORMAT, 8'h38);
    rd(rsmd_pkg::OFS_LINE_FORMAT, 8'h38, "line format");
    wr(rsmd_pkg::OFS_INT_ENABLE, 8'h04);
    rx(1'b0, 8'h33, 11'h066, "off drop");
    rx(1'b1, 8'h42, 11'h685, "addr");
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h01);
    rx(1'b0, 8'h77, 11'h4ee, "data");
    rx(1'b1, 8'h43, 11'h687, "addr again");
  endtask
  task t_auto;
    wr(rsmd_pkg::OFS_ENH_FEATURE, 8'h20);
    wr(rsmd_pkg::OFS_PAUSE_CHAR2, 8'h5a);
    wr(rsmd_pkg::OFS_EVT_MASK, 8'h02);
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h03);
    rx(1'b1, 8'h11, 11'h222, "mismatch");
    rx(1'b0, 8'h66, 11'h0cc, "data drop");
    rx(1'b1, 8'h5a, 11'h6b5, "match");
    rd(rsmd_pkg::OFS_LINK_STATUS, 8'h05, "rx on");
    rx(1'b0, 8'h66, 11'h4cc, "data kept");
    rx(1'b1, 8'h11, 11'h222, "later miss");
    rd(rsmd_pkg::OFS_LINK_STATUS, 8'h00, "rx off");
    chk("irq set", irq, 1'b1);
    wr(rsmd_pkg::OFS_EVT_STATUS, 8'h02);
    rd(rsmd_pkg::OFS_EVT_STATUS, 8'h01, "status");
    chk("irq clr", irq, 1'b0);
    wr(rsmd_pkg::OFS_INT_ENABLE, 8'h00);
    rx(1'b1, 8'h5a, 11'h6b4, "masked");
    rd(4'hf, 8'h00, "unmapped");
    rd(rsmd_pkg::OFS_PAUSE_CHAR2, 8'h5a, "pause char");
  endtask
  task t_flush;
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h02);
    rx(1'b0, 8'h55, 11'h0aa, "off plain");
    sb <= 1'b1;
    rx(1'b0, 8'h55, 11'h4aa, "flush");
    sb <= 1'b0;
    wr(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h00);
    rx(1'b1, 8'h55, 11'h4aa, "plain ninth");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run needs well under 600 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    {clk, rst_n, wr_stb, rd_stb, hdl, txw, txd, sb} = '0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(rsmd_pkg::OFS_EXTRA_FEATURE, 8'h00, "reset exf");
    t_dir;
    t_norm;
    t_auto;
    t_flush;
    give_verdict;
  end
endmodule
`default_nettype wire
